// [pkg/dsq_pkg.sv]
// constants shared by the conversion sequencer and its decimator
// assumes a single 100 MHz clock domain with synchronous active-high reset
package dsq_pkg;
   // ===================================================
   // modulator and decimation
   localparam int MOD_DIV = 6;       // system clocks per modulator clock
   localparam int OSR = 64;          // modulator clocks per output word
   localparam int ORDER = 5;         // sinc order
   localparam int SETTLE_CONV = 5;   // conversions before data is valid
   localparam int SETTLE_SYS_CLK = SETTLE_CONV * OSR * MOD_DIV;
   localparam int WORD_W = 24;       // result word width
   localparam int ACC_W = 31;        // ORDER*log2(OSR)+1 accumulator bits
   localparam int CNT_W = 8;         // width of small counters
   // ===================================================
   // data-ready framing on the shared result line, in system clocks
   localparam int FLAG_LOW_CYC = 6;  // low pulse announcing a new word
   localparam int FLAG_HIGH_CYC = 6; // high gap before shifting starts
   // ===================================================
   // input pair codes as seen on the two pick pins
   localparam logic [1:0] INPUT_PAIR_ONE = 2'h0;
   localparam logic [1:0] INPUT_PAIR_TWO = 2'h1;
   localparam logic [1:0] INPUT_PAIR_THREE = 2'h2;
   localparam logic [1:0] INPUT_PAIR_FOUR = 2'h3;
   localparam logic [1:0] PICK_RST = 2'h0;
   localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
   localparam logic [WORD_W-1:0] WORD_MAX = 24'h7fffff;
   typedef enum logic [1:0] {
      st_idle, st_flag_low, st_flag_high, st_shift
   } line_state_t;
endpackage

// [pkg/dec_if.sv]
// carrier between the sequencer and the decimator
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface dec_if;
   import dsq_pkg::*;
   logic mod_en;                // one pulse per modulator clock
   logic mod_bit;               // modulator bitstream sample
   logic clear;                 // wipe filter and phase
   logic word_valid;            // one-cycle pulse per finished word
   logic [WORD_W-1:0] word;     // registered result
   modport seq (output mod_en, output mod_bit, output clear,
                input word_valid, input word);
   modport dec (input mod_en, input mod_bit, input clear,
                output word_valid, output word);
endinterface

// [design/fifth_order_decimator.sv]
// fifth-order sinc decimator: integrators at modulator rate, combs at
// word rate; assumes mod_en is a one-cycle enable from the sequencer
`timescale 1ns/1ps
module fifth_order_decimator (
   input wire logic clock,
   input wire logic sys_rst,
   dec_if.dec link
);
   import dsq_pkg::*;
   // ===================================================
   // state
   logic [ACC_W-1:0] integ_ff [ORDER];
   logic [ACC_W-1:0] nxt_integ [ORDER];
   logic [ACC_W-1:0] dly_ff [ORDER];
   logic [ACC_W-1:0] nxt_dly [ORDER];
   logic [CNT_W-1:0] phase_ff, nxt_phase;
   logic valid_ff, nxt_valid;
   logic [WORD_W-1:0] word_ff, nxt_word;

   // map unsigned 0..2^30 sum to a signed word, clipping the top code
   function automatic logic [WORD_W-1:0] to_word(logic [ACC_W-1:0] s);
      logic [ACC_W-1:0] c;
      c = s - (ACC_W)'(1 << (ACC_W - 2));
      if (s[ACC_W-1])
         return WORD_MAX;
      return c[ACC_W-2 -: WORD_W];
   endfunction

   // integrators wrap modulo 2^ACC_W; the combs undo the wrap exactly
   always_comb begin
      logic [ACC_W-1:0] x;
      x = '0;
      nxt_integ = integ_ff;
      nxt_dly = dly_ff;
      nxt_phase = phase_ff;
      nxt_valid = 1'b0;
      nxt_word = word_ff;
      if (link.clear) begin
         for (int i = 0; i < ORDER; i++) begin
            nxt_integ[i] = '0;
            nxt_dly[i] = '0;
         end
         nxt_phase = '0;
      end else if (link.mod_en) begin
         nxt_integ[0] = integ_ff[0] + {{(ACC_W-1){1'b0}}, link.mod_bit};
         for (int i = 1; i < ORDER; i++) begin
            nxt_integ[i] = integ_ff[i] + integ_ff[i-1];
         end
         nxt_phase = phase_ff + 8'h01;
         if (phase_ff == (CNT_W)'(OSR - 1)) begin
            nxt_phase = '0;
            x = integ_ff[ORDER-1];
            for (int i = 0; i < ORDER; i++) begin
               nxt_dly[i] = x;
               x = x - dly_ff[i];
            end
            nxt_word = to_word(x);
            nxt_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < ORDER; i++) begin
            integ_ff[i] <= '0;
            dly_ff[i] <= '0;
         end
         phase_ff <= '0;
         valid_ff <= 1'b0;
         word_ff <= WORD_RST;
      end else begin
         integ_ff <= nxt_integ;
         dly_ff <= nxt_dly;
         phase_ff <= nxt_phase;
         valid_ff <= nxt_valid;
         word_ff <= nxt_word;
      end
   end

   assign link.word_valid = valid_ff;
   assign link.word = word_ff;
endmodule

// [design/delta_sigma_conversion_sequencer.sv]
// conversion sequencer: modulator clock divider, channel pick watch,
// settle gating and the shared data-ready / serial result line
// assumes serial_clock and the pick pins are synchronous to clock
//
// Notes on behaviour
// - modulator clock is the system clock divided by six
// - one output word every 64 modulator clocks
// - word rate follows the system clock linearly
// - fifth-order sinc filter feeds each settled result into the output register
// - new result announced by pulling the result line low
// - pick pins 00,01,10,11 select input pairs one to four
// - pick pins sampled on falling clock edge; any change restarts
// - after restart, ready only after five conversions have elapsed
// - result bits leave on serial clock falling edge, msb first
// - full settling takes five conversions, 1920 system clocks
`timescale 1ns/1ps
module delta_sigma_conversion_sequencer #(
   parameter int DIV = dsq_pkg::MOD_DIV
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic mod_bit,
   input wire logic channel_pick_high,
   input wire logic channel_pick_low,
   input wire logic serial_clock,
   output logic result_out_ready_line,
   output logic [1:0] active_pair,
   output logic modulator_clock
);
   import dsq_pkg::*;

   // refused at elaboration: the divider counter is CNT_W bits wide
   // and the modulator clock needs a high and a low phase
   if (DIV < 2 || DIV > 255) begin
      $error("DIV must lie in 2..255");
   end

   dec_if link ();

   fifth_order_decimator u_dec (
      .clock(clock),
      .sys_rst(sys_rst),
      .link(link)
   );

   // ===================================================
   // modulator clock divider
   logic [CNT_W-1:0] div_ff, nxt_div;
   logic mod_en_ff, nxt_mod_en;
   logic mclk_ff, nxt_mclk;
   // declared here: the divider realigns on a pick change
   logic restart;

   // counts system clocks, so the word rate tracks the clock rate
   always_comb begin
      nxt_div = div_ff + 8'h01;
      nxt_mod_en = 1'b0;
      if (div_ff == (CNT_W)'(DIV - 1)) begin
         nxt_div = '0;
         nxt_mod_en = 1'b1;
      end
      nxt_mclk = (div_ff < (CNT_W)'(DIV / 2));
      if (restart) begin
         nxt_div = '0;
         nxt_mod_en = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         div_ff <= '0;
         mod_en_ff <= 1'b0;
         mclk_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         mod_en_ff <= nxt_mod_en;
         mclk_ff <= nxt_mclk;
      end
   end

   // ===================================================
   // channel pick watch
   logic [1:0] pick_fall_ff, nxt_pick_fall;
   logic [1:0] pick_ff;

   // falling-edge capture gives the pins half a cycle of setup margin
   assign nxt_pick_fall = {channel_pick_high, channel_pick_low};

   always_ff @(negedge clock) begin
      if (sys_rst)
         pick_fall_ff <= PICK_RST;
      else
         pick_fall_ff <= nxt_pick_fall;
   end

   // any difference from the active pick restarts the conversion
   assign restart = (pick_fall_ff != pick_ff);

   always_ff @(posedge clock) begin
      if (sys_rst)
         pick_ff <= PICK_RST;
      else
         pick_ff <= pick_fall_ff;
   end

   // ===================================================
   // decimator feed and settle gating
   logic [CNT_W-1:0] conv_ff, nxt_conv;
   logic [WORD_W-1:0] out_reg_ff, nxt_out_reg;
   logic deliver;

   assign link.mod_en = mod_en_ff;
   assign link.mod_bit = mod_bit;
   assign link.clear = restart;

   // words before the filter fills are built from the cleared filter state: drop them
   always_comb begin
      nxt_conv = conv_ff;
      deliver = 1'b0;
      nxt_out_reg = out_reg_ff;
      if (restart) begin
         nxt_conv = '0;
      end else if (link.word_valid) begin
         if (conv_ff >= (CNT_W)'(SETTLE_CONV - 1)) begin
            deliver = 1'b1;
            nxt_out_reg = link.word;
         end else begin
            nxt_conv = conv_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         conv_ff <= '0;
         out_reg_ff <= WORD_RST;
      end else begin
         conv_ff <= nxt_conv;
         out_reg_ff <= nxt_out_reg;
      end
   end

   // ===================================================
   // result line: ready pulse then msb-first shifting
   line_state_t st_ff, nxt_st;
   logic [CNT_W-1:0] tmr_ff, nxt_tmr;
   logic [WORD_W-1:0] shift_ff, nxt_shift;
   logic line_ff, nxt_line;
   logic sclk_prev_ff;
   logic sclk_fall;

   assign sclk_fall = sclk_prev_ff & ~serial_clock;

   // extra clocks beyond the word shift in zeros, so the line stays low
   always_comb begin
      nxt_st = st_ff;
      nxt_tmr = tmr_ff;
      nxt_shift = shift_ff;
      nxt_line = line_ff;
      case (st_ff)
         st_idle: begin
            nxt_line = 1'b1;
         end
         st_flag_low: begin
            nxt_line = 1'b0;
            nxt_tmr = tmr_ff + 8'h01;
            if (tmr_ff == (CNT_W)'(FLAG_LOW_CYC - 1)) begin
               nxt_tmr = '0;
               nxt_st = st_flag_high;
               nxt_line = 1'b1;
            end
         end
         st_flag_high: begin
            nxt_line = 1'b1;
            nxt_tmr = tmr_ff + 8'h01;
            if (tmr_ff == (CNT_W)'(FLAG_HIGH_CYC - 1)) begin
               nxt_st = st_shift;
               // shifter loads from the output register at frame end
               nxt_shift = out_reg_ff;
               nxt_line = out_reg_ff[WORD_W-1];
            end
         end
         st_shift: begin
            if (sclk_fall) begin
               nxt_shift = {shift_ff[WORD_W-2:0], 1'b0};
               nxt_line = shift_ff[WORD_W-2];
            end
         end
         default: begin
            nxt_st = st_idle;
            nxt_line = 1'b1;
         end
      endcase
      // a new word always restarts the frame at its low pulse, even mid-shift
      if (deliver) begin
         nxt_st = st_flag_low;
         nxt_tmr = '0;
         nxt_line = 1'b0;
      end
      if (restart) begin
         nxt_st = st_idle;
         nxt_line = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_ff <= st_idle;
         tmr_ff <= '0;
         shift_ff <= WORD_RST;
         line_ff <= 1'b1;
         sclk_prev_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         shift_ff <= nxt_shift;
         line_ff <= nxt_line;
         sclk_prev_ff <= serial_clock;
      end
   end

   assign result_out_ready_line = line_ff;
   assign active_pair = pick_ff;
   assign modulator_clock = mclk_ff;
endmodule

// [dv/dsq_assertions.sv]
// port checker for the conversion sequencer
// assumes the reader holds sclk high 2 and low 3 clocks
`timescale 1ns/1ps
module dsq_assertions #(
   parameter int DIV = 6
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic channel_pick_high,
   input wire logic channel_pick_low,
   input wire logic serial_clock,
   input wire logic result_out_ready_line,
   input wire logic [1:0] active_pair,
   input wire logic modulator_clock
);
   // =====
   // restart watch and settle counter
   localparam int SETTLE = 5 * 64 * DIV;
   logic [1:0] pair_ff;
   logic [1:0] nxt_pair;
   logic [11:0] since_ff;
   logic [11:0] nxt_since;
   logic restart;
   assign restart = active_pair != pair_ff;
   // saturates, so a plain reset never looks like a restart
   always_comb begin
      nxt_pair = active_pair;
      nxt_since = since_ff + {11'h0, since_ff != 12'hfff};
      if (sys_rst) begin
         nxt_since = 12'hfff;
      end else if (restart) begin
         nxt_since = 12'h0;
      end
   end
   always_ff @(posedge clock) begin
      pair_ff <= nxt_pair;
      since_ff <= nxt_since;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst || restart);
   // =====
   // properties
   AST_RESET_IDLE: assert property (disable iff (1'b0)
      sys_rst |=> result_out_ready_line && active_pair == 2'h0 &&
      !modulator_clock) else $error("outputs not idle in reset");
   AST_MODCLK_SHAPE: assert property (
      $rose(modulator_clock) |-> modulator_clock [*3] ##1
      !modulator_clock [*3] ##1 modulator_clock)
      else $error("modulator clock not clock over six");
   AST_PAIR_FOLLOW: assert property (disable iff (sys_rst)
      1'b1 |=> active_pair == $past({channel_pick_high, channel_pick_low}))
      else $error("active pair does not follow pins");
   AST_RESTART_IDLE: assert property (disable iff (sys_rst)
      restart |-> result_out_ready_line) else $error("line busy on restart");
   AST_SETTLE_HOLD: assert property (
      since_ff < SETTLE |-> result_out_ready_line)
      else $error("ready before settling");
   AST_SETTLE_READY: assert property (
      since_ff == SETTLE |-> ##[1:60] !result_out_ready_line)
      else $error("no ready after settling");
   AST_FLAG_LOW: assert property (
      $fell(result_out_ready_line) && !$past(serial_clock) &&
      !$past(serial_clock, 2) && !$past(serial_clock, 3)
      |-> !result_out_ready_line [*6]) else $error("ready pulse too short");
   AST_SHIFT_HOLD: assert property (
      $rose(serial_clock) |-> $stable(result_out_ready_line) [*3])
      else $error("data moved on sclk rise");
   cover property (disable iff (sys_rst) restart);
   cover property (since_ff == SETTLE);
   cover property ($rose(serial_clock));
endmodule
bind delta_sigma_conversion_sequencer dsq_assertions #(.DIV(DIV)) u_chk (
   .clock(clock), .sys_rst(sys_rst), .channel_pick_high(channel_pick_high),
   .channel_pick_low(channel_pick_low), .serial_clock(serial_clock),
   .result_out_ready_line(result_out_ready_line),
   .active_pair(active_pair), .modulator_clock(modulator_clock));

// [dv/result_reader.sv]
// reader model: waits for the ready frame, then clocks out one word
// assumes enable is dropped by the bench before a pair swap
`timescale 1ns/1ps
module result_reader (
   input wire logic clock,
   input wire logic line,
   input wire logic enable,
   output logic serial_clock,
   output logic [dsq_pkg::WORD_W-1:0] word,
   output logic got
);
   import dsq_pkg::*;
   // =====
   // low frame, high gap, then one bit per sclk rise
   initial begin
      serial_clock = 1'b0; // idle low outside reads
      got = 1'b0;
      word = '0;
      forever begin
         @(posedge clock);
         got <= 1'b0;
         if (enable && !line) begin
            while (!line && enable) @(posedge clock);
            if (enable) begin
               repeat (10) @(posedge clock); // clears the high gap
               for (int i = 0; i < WORD_W; i++) begin
                  serial_clock <= 1'b1;
                  word <= {word[WORD_W-2:0], line};
                  repeat (2) @(posedge clock);
                  serial_clock <= 1'b0;
                  repeat (3) @(posedge clock);
               end
               got <= 1'b1;
            end
         end
      end
   end
endmodule

// [dv/delta_sigma_conversion_sequencer_test.sv]
// self-checking bench for the conversion sequencer
// assumes the reader model and port checker are compiled alongside
`timescale 1ns/1ps
module delta_sigma_conversion_sequencer_test;
   import dsq_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic mod_bit = 1'b1;
   logic pick_h = 1'b0;
   logic pick_l = 1'b0;
   logic rd_en = 1'b0;
   logic sclk, line, got, mclk;
   logic [1:0] pair;
   logic [WORD_W-1:0] word;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   int g;
   always #5 clock = ~clock;
   delta_sigma_conversion_sequencer DUT (.clock(clock), .sys_rst(sys_rst),
      .mod_bit(mod_bit), .channel_pick_high(pick_h),
      .channel_pick_low(pick_l), .serial_clock(sclk),
      .result_out_ready_line(line), .active_pair(pair),
      .modulator_clock(mclk));
   result_reader u_reader (.clock(clock), .line(line), .enable(rd_en),
      .serial_clock(sclk), .word(word), .got(got));
   // =====
   // shared checks
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // clocks until the reader finishes a word
   task automatic next_word(output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (got !== 1'b1 && n < 3000);
      check(got, 1'b1);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard, well above the ~11k clocks needed
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         wrap_up();
      end
   end
   // =====
   // scenarios
   // reader parked during the swap, else it reads the idle line
   task automatic t_pick(input logic [1:0] code);
      int n;
      n = 0;
      rd_en <= 1'b0;
      {pick_h, pick_l} <= code;
      do begin
         @(posedge clock);
         n++;
      end while ((line !== 1'b0 || n < 3) && n < 3000);
      check(pair, code);
      check(n >= SETTLE_SYS_CLK && n < SETTLE_SYS_CLK + 60, 1);
      rd_en <= 1'b1;
      next_word(n);
      check(word, WORD_MAX);
      $display("pick %0d done", code);
   endtask
   // back-to-back words, then five clean windows of zeros
   task automatic t_rate();
      int hi;
      hi = 0;
      next_word(g);
      check(g, OSR * MOD_DIV);
      check(word, WORD_MAX);
      mod_bit <= 1'b0;
      repeat (6) next_word(g);
      check(g, OSR * MOD_DIV);
      check(word, WORD_MAX + 24'h1);
      // one full modulator period: high for half of it
      repeat (MOD_DIV) begin
         @(posedge clock);
         hi += mclk;
      end
      check(hi, MOD_DIV / 2);
      $display("rate done");
   endtask
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_pick(INPUT_PAIR_TWO);
      t_pick(INPUT_PAIR_THREE);
      t_pick(INPUT_PAIR_FOUR);
      t_pick(INPUT_PAIR_ONE);
      t_rate();
      wrap_up();
   end
endmodule
